/* design/anvr_host.v */
// host controller pacing accesses to a clockless 512k x 16 nonvolatile memory
`include "anvr_consts.vh"

module anvr_host (
  input  wire                   clk,
  input  wire                   arst_n,
  input  wire                   low_supply,
  input  wire                   req_valid,
  input  wire [2:0]             req_cmd,
  input  wire [`ANVR_AW-1:0]    req_addr,
  input  wire [`ANVR_DW-1:0]    req_wdata,
  input  wire [1:0]             req_lanes,
  output reg                    req_ready_r,
  output reg                    rsp_valid_r,
  output reg  [`ANVR_DW-1:0]    rsp_rdata_r,
  output reg                    power_safe_r,
  output reg                    chip_select_n_r,
  output reg                    write_strobe_n_r,
  output reg                    output_enable_n_r,
  output reg                    upper_byte_enable_n_r,
  output reg                    lower_byte_enable_n_r,
  output reg                    sleep_request_n_r,
  output reg  [`ANVR_AW-1:0]    word_address_pins_r,
  output reg  [`ANVR_DW-1:0]    data_pins_out_r,
  output reg                    data_pins_oe_r,
  input  wire [`ANVR_DW-1:0]    data_pins_in
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] ST_PWRUP   = 4'h0;
  localparam [3:0] ST_IDLE    = 4'h1;
  localparam [3:0] ST_RD      = 4'h2;
  localparam [3:0] ST_WR      = 4'h3;
  localparam [3:0] ST_PRECHG  = 4'h4;
  localparam [3:0] ST_PAGE    = 4'h5;
  localparam [3:0] ST_PG_WR   = 4'h6;
  localparam [3:0] ST_PG_RD   = 4'h7;
  localparam [3:0] ST_SLEEP   = 4'h8;
  localparam [3:0] ST_WAKE    = 4'h9;
  localparam [3:0] ST_PWROFF  = 4'ha;
  localparam [3:0] ST_OFF     = 4'hb;
  localparam [3:0] ST_PUWAIT  = 4'hc;
  localparam [`ANVR_CW-1:0] PU_CYC   = `ANVR_PU_CYC;
  localparam [`ANVR_CW-1:0] ZZEX_CYC = `ANVR_ZZEX_CYC;
  localparam [`ANVR_CW-1:0] ZZL_CYC  = `ANVR_ZZL_CYC;
  localparam [`ANVR_CW-1:0] AWH_LO   = `ANVR_AWH_LO_CYC;
  localparam [`ANVR_CW-1:0] AWH_HI   = `ANVR_AWH_HI_CYC;
  localparam [`ANVR_CW-1:0] WPP_CYC  = `ANVR_WPP_CYC;
  localparam [`ANVR_CW-1:0] PWC_CYC  = `ANVR_PWC_CYC;
  localparam [`ANVR_CW-1:0] PRC_CYC  = `ANVR_PRC_CYC;
  localparam [`ANVR_CW-1:0] RC_CYC   = `ANVR_RC_CYC;
  localparam [`ANVR_CW-1:0] PC_CYC   = `ANVR_PC_CYC;
  localparam [`ANVR_CW-1:0] PD_CYC   = `ANVR_PD_CYC;

  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  reg  [3:0]            state_r;
  reg  [3:0]            state_nxt;
  reg                   tmr_load;
  reg  [`ANVR_CW-1:0]   tmr_count;
  wire                  tmr_done;
  reg                   supply_lo_r;
  reg  [`ANVR_CW-1:0]   awh_cyc;
  reg  [`ANVR_CW-1:0]   rd_cyc;
  reg  [`ANVR_CW-1:0]   pulse_r;
  reg  [2:0]            sup_sync_r;
  anvr_timer u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (tmr_load),
    .count  (tmr_count),
    .done_r (tmr_done)
  );

  // the supply strap is caught after reset and held; a live change mid-access would
  // shorten an interval already under way
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sup_sync_r  <= 3'h7;
      supply_lo_r <= 1'b1;
    end else begin
      sup_sync_r <= {sup_sync_r[1:0], low_supply};
      if (state_r == ST_PUWAIT && sup_sync_r[1] == sup_sync_r[2]) begin
        supply_lo_r <= sup_sync_r[2];
      end
    end
  end
  // low supply takes the longer figure; whole cycles rounded up
  always @* begin
    awh_cyc = supply_lo_r ? AWH_LO : AWH_HI;
    rd_cyc  = (awh_cyc > RC_CYC) ? awh_cyc : RC_CYC;
  end
  wire take = req_valid & req_ready_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_count = 16'h0000;
    case (state_r)
      ST_PWRUP: begin
        state_nxt = ST_PUWAIT;
        tmr_load  = 1'b1;
        tmr_count = PU_CYC;
      end
      ST_IDLE: begin
        if (take) begin
          tmr_load = 1'b1;
          case (req_cmd)
            `ANVR_CMD_READ: begin
              state_nxt = ST_RD;
              tmr_count = rd_cyc;
            end
            `ANVR_CMD_WRITE: begin
              state_nxt = ST_WR;
              tmr_count = awh_cyc;
            end
            `ANVR_CMD_PG_READ: begin
              state_nxt = ST_PG_RD;
              tmr_count = awh_cyc;
            end
            `ANVR_CMD_PG_WRITE: begin
              state_nxt = ST_PG_WR;
              tmr_count = awh_cyc;
            end
            `ANVR_CMD_SLEEP: begin
              state_nxt = ST_SLEEP;
              tmr_count = ZZL_CYC;
            end
            `ANVR_CMD_PWR_OFF: begin
              state_nxt = ST_PWROFF;
              tmr_count = PD_CYC;
            end
            default: begin
              tmr_load = 1'b0;
            end
          endcase
        end
      end
      ST_RD, ST_WR: begin
        if (tmr_done) begin
          state_nxt = ST_PRECHG;
          tmr_load  = 1'b1;
          tmr_count = PC_CYC;
        end
      end
      ST_PUWAIT, ST_PRECHG, ST_WAKE: begin
        if (tmr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_PG_WR, ST_PG_RD: begin
        if (tmr_done && pulse_r == 16'h0000) begin
          state_nxt = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (take) begin
          tmr_load = 1'b1;
          case (req_cmd)
            `ANVR_CMD_PG_WRITE: begin
              state_nxt = ST_PG_WR;
              tmr_count = PWC_CYC;
            end
            `ANVR_CMD_PG_READ: begin
              state_nxt = ST_PG_RD;
              tmr_count = PRC_CYC;
            end
            default: begin
              state_nxt = ST_PRECHG;
              tmr_count = PC_CYC;
            end
          endcase
        end
      end
      ST_SLEEP: begin
        if (take && tmr_done && req_cmd == `ANVR_CMD_WAKE) begin
          state_nxt = ST_WAKE;
          tmr_load  = 1'b1;
          tmr_count = ZZEX_CYC;
        end
      end
      ST_PWROFF: begin
        if (tmr_done) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        state_nxt = ST_OFF;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pins and answers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r               <= ST_PWRUP;
      pulse_r               <= 16'h0000;
      req_ready_r           <= 1'b0;
      rsp_valid_r           <= 1'b0;
      rsp_rdata_r           <= 16'h0000;
      power_safe_r          <= 1'b0;
      chip_select_n_r       <= 1'b1;
      write_strobe_n_r      <= 1'b1;
      output_enable_n_r     <= 1'b1;
      upper_byte_enable_n_r <= 1'b1;
      lower_byte_enable_n_r <= 1'b1;
      sleep_request_n_r     <= 1'b1;
      word_address_pins_r   <= 19'h00000;
      data_pins_out_r       <= 16'h0000;
      data_pins_oe_r        <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      rsp_valid_r <= 1'b0;
      if (pulse_r != 16'h0000) begin
        pulse_r <= pulse_r - 16'h0001;
      end
      // ready where a request can start at once, and in sleep even before its low time has run; a long pulse keeps it low
      req_ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_SLEEP) ||
                     (state_nxt == ST_PAGE && !tmr_load);
      if (tmr_load) begin
        case (state_nxt)
          ST_RD, ST_WR, ST_PG_RD, ST_PG_WR: begin
            chip_select_n_r       <= 1'b0;
            word_address_pins_r   <= req_addr;
            upper_byte_enable_n_r <= ~req_lanes[1];
            lower_byte_enable_n_r <= ~req_lanes[0];
            if (state_nxt == ST_WR || state_nxt == ST_PG_WR) begin
              write_strobe_n_r  <= 1'b0;
              output_enable_n_r <= 1'b1;
              data_pins_out_r   <= req_wdata;
              data_pins_oe_r    <= 1'b1;
              pulse_r           <= WPP_CYC;
            end else begin
              write_strobe_n_r  <= 1'b1;
              output_enable_n_r <= 1'b0;
              data_pins_oe_r    <= 1'b0;
            end
          end
          ST_SLEEP: begin
            sleep_request_n_r <= 1'b0;
          end
          ST_WAKE: begin
            sleep_request_n_r <= 1'b1;
          end
          default: begin
            chip_select_n_r       <= 1'b1;
            write_strobe_n_r      <= 1'b1;
            output_enable_n_r     <= 1'b1;
            upper_byte_enable_n_r <= 1'b1;
            lower_byte_enable_n_r <= 1'b1;
            data_pins_oe_r        <= 1'b0;
          end
        endcase
      end else if (state_r == ST_PG_WR && tmr_done && pulse_r == 16'h0000) begin
        // a single write leaves through pre-charge, so lanes rise with its strobe
        write_strobe_n_r <= 1'b1;
      end
      // sample read data the cycle the access ends, before the outputs float
      if ((state_r == ST_RD || state_r == ST_PG_RD) && tmr_done) begin
        rsp_valid_r <= 1'b1;
        rsp_rdata_r <= data_pins_in;
      end
      if (state_r == ST_SLEEP || state_r == ST_WAKE) begin
        chip_select_n_r   <= 1'b1;
        write_strobe_n_r  <= 1'b1;
        output_enable_n_r <= 1'b1;
      end
      power_safe_r <= (state_nxt == ST_OFF);
    end
  end

endmodule

/* design/anvr_consts.vh */
// timing constants and request command encodings for the nonvolatile memory host controller
`ifndef ANVR_CONSTS_VH
`define ANVR_CONSTS_VH

// clock period in ns
`define ANVR_CLK_NS        10
// page write cycle, page write pulse, page read cycle (ns)
`define ANVR_PWC_NS        25
`define ANVR_WPP_NS        16
`define ANVR_PRC_NS        25
// address change to write strobe rise, low and high supply (ns)
`define ANVR_AWH_LO_NS     135
`define ANVR_AWH_HI_NS     120
// byte-lane write pulse and strobe-low-to-lane-high (ns)
`define ANVR_WP2_NS        20
`define ANVR_WP3_NS        20
// power-down chip select hold (ns), read cycle (ns), chip select pre-charge (ns)
`define ANVR_PD_NS         85
`define ANVR_RC_NS         120
`define ANVR_PC_NS         55
// power-up and sleep exit hold (us), sleep request low time (us)
`define ANVR_PU_US         450
`define ANVR_ZZEX_US       450
`define ANVR_ZZL_US        1

// least times rounded up to whole cycles
`define ANVR_CYC_UP(t)     (((t) + `ANVR_CLK_NS - 1) / `ANVR_CLK_NS)
`define ANVR_PWC_CYC       `ANVR_CYC_UP(`ANVR_PWC_NS)
`define ANVR_WPP_CYC       `ANVR_CYC_UP(`ANVR_WPP_NS)
`define ANVR_PRC_CYC       `ANVR_CYC_UP(`ANVR_PRC_NS)
`define ANVR_AWH_LO_CYC    `ANVR_CYC_UP(`ANVR_AWH_LO_NS)
`define ANVR_AWH_HI_CYC    `ANVR_CYC_UP(`ANVR_AWH_HI_NS)
`define ANVR_WP2_CYC       `ANVR_CYC_UP(`ANVR_WP2_NS)
`define ANVR_WP3_CYC       `ANVR_CYC_UP(`ANVR_WP3_NS)
`define ANVR_PD_CYC        `ANVR_CYC_UP(`ANVR_PD_NS)
`define ANVR_RC_CYC        `ANVR_CYC_UP(`ANVR_RC_NS)
`define ANVR_PC_CYC        `ANVR_CYC_UP(`ANVR_PC_NS)
`define ANVR_PU_CYC        `ANVR_CYC_UP(`ANVR_PU_US * 1000)
`define ANVR_ZZEX_CYC      `ANVR_CYC_UP(`ANVR_ZZEX_US * 1000)
`define ANVR_ZZL_CYC       `ANVR_CYC_UP(`ANVR_ZZL_US * 1000)

// widths
`define ANVR_AW            19
`define ANVR_DW            16
`define ANVR_CW            16

// request commands
`define ANVR_CMD_READ      3'h0
`define ANVR_CMD_WRITE     3'h1
`define ANVR_CMD_PG_READ   3'h2
`define ANVR_CMD_PG_WRITE  3'h3
`define ANVR_CMD_PG_END    3'h4
`define ANVR_CMD_SLEEP     3'h5
`define ANVR_CMD_WAKE      3'h6
`define ANVR_CMD_PWR_OFF   3'h7

`endif

/* design/anvr_timer.v */
// down counter that flags when a loaded interval has run out
`include "anvr_consts.vh"

module anvr_timer (
  input  wire                   clk,
  input  wire                   arst_n,
  input  wire                   load,
  input  wire [`ANVR_CW-1:0]    count,
  output reg                    done_r
);

  reg [`ANVR_CW-1:0] cnt_r;

  // done is registered so a loaded value of n gives done n cycles later
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 16'h0000;
      done_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= count;
      done_r <= (count == 16'h0000);
    end else if (cnt_r != 16'h0000) begin
      cnt_r  <= cnt_r - 16'h0001;
      done_r <= (cnt_r == 16'h0001);
    end else begin
      done_r <= 1'b1;
    end
  end

endmodule

/* test/anvr_host_props.sv */
// assertions on the memory pins of the host controller
`include "anvr_consts.vh"

module anvr_host_props (
  input wire                clk,
  input wire                arst_n,
  input wire                low_supply,
  input wire                power_safe_r,
  input wire                chip_select_n_r,
  input wire                write_strobe_n_r,
  input wire                output_enable_n_r,
  input wire                upper_byte_enable_n_r,
  input wire                lower_byte_enable_n_r,
  input wire                sleep_request_n_r,
  input wire [`ANVR_AW-1:0] word_address_pins_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // run counters, saturating so long idles never wrap
  // ----------
  reg [15:0]         slp_r;
  reg                slp_q_r;
  reg [15:0]         run_r;
  reg                cs_q_r;
  reg [15:0]         adr_r;
  reg [`ANVR_AW-1:0] a_q_r;
  reg [15:0]         gap_r;
  reg [15:0]         we_r;
  reg                multi_r;
  wire               chg = word_address_pins_r != a_q_r;
  wire [15:0]        awh = low_supply ? 16'(`ANVR_AWH_LO_CYC) : 16'(`ANVR_AWH_HI_CYC);

  function [15:0] inc(input [15:0] v);
    inc = (v == 16'hffff) ? v : v + 16'h1;
  endfunction

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slp_r   <= 16'h0;
      slp_q_r <= 1'b1;
      run_r   <= 16'h0;
      cs_q_r  <= 1'b1;
      adr_r   <= 16'hffff;
      a_q_r   <= {`ANVR_AW{1'b0}};
      gap_r   <= 16'hffff;
      we_r    <= 16'h0;
      multi_r <= 1'b0;
    end else begin
      slp_r   <= (sleep_request_n_r != slp_q_r) ? 16'h1 : inc(slp_r);
      slp_q_r <= sleep_request_n_r;
      run_r   <= (chip_select_n_r != cs_q_r) ? 16'h1 : inc(run_r);
      cs_q_r  <= chip_select_n_r;
      adr_r   <= chg ? 16'h1 : inc(adr_r);
      a_q_r   <= word_address_pins_r;
      gap_r   <= (!chip_select_n_r && cs_q_r) ? 16'h1 : inc(gap_r);
      we_r    <= write_strobe_n_r ? 16'h0 : inc(we_r);
      // page mode: address moves while the chip stays selected
      multi_r <= !chip_select_n_r && (multi_r || (chg && !cs_q_r));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_cs_hold: assert property (
    $fell(chip_select_n_r) |-> sleep_request_n_r && slp_r >= `ANVR_PU_CYC)
    else $error("chip select active inside the idle hold");
  a_addr_hold: assert property (
    $rose(write_strobe_n_r) && !multi_r |-> run_r >= awh && adr_r >= awh)
    else $error("write strobe rose too soon after the address");
  a_read_cycle: assert property (
    $fell(chip_select_n_r) |-> gap_r >= `ANVR_RC_CYC)
    else $error("chip select cycles too close");
  a_page_pace: assert property (
    !chip_select_n_r && !cs_q_r && chg |-> adr_r >= `ANVR_PWC_CYC)
    else $error("page address changes too close");
  a_strobe_width: assert property (
    $fell(write_strobe_n_r) |-> !write_strobe_n_r [*2])
    else $error("write strobe pulse too short");
  a_lane_width: assert property (
    $fell(lower_byte_enable_n_r) |-> !lower_byte_enable_n_r [*2])
    else $error("lane enable pulse too short");
  a_lane_release: assert property (
    ($rose(upper_byte_enable_n_r) || $rose(lower_byte_enable_n_r)) &&
    !$past(write_strobe_n_r) |-> we_r >= `ANVR_WP3_CYC)
    else $error("lanes released too soon after strobe fell");
  a_pwroff_hold: assert property (
    $rose(power_safe_r) |-> chip_select_n_r && run_r >= `ANVR_PD_CYC)
    else $error("power safe flagged too early");
  a_sleep_width: assert property (
    $rose(sleep_request_n_r) |-> slp_r >= `ANVR_ZZL_CYC)
    else $error("sleep request too short");
  a_sleep_idle: assert property (
    !sleep_request_n_r |-> chip_select_n_r && write_strobe_n_r && output_enable_n_r)
    else $error("controls active while asleep");

  c_write: cover property ($rose(write_strobe_n_r) && !multi_r);
  c_page: cover property (multi_r);
  c_wake: cover property ($rose(sleep_request_n_r));
  c_pwroff: cover property ($rose(power_safe_r));
endmodule

bind anvr_host anvr_host_props chk_u (
  .clk, .arst_n, .low_supply, .power_safe_r, .chip_select_n_r, .write_strobe_n_r,
  .output_enable_n_r, .upper_byte_enable_n_r, .lower_byte_enable_n_r,
  .sleep_request_n_r, .word_address_pins_r);

/* test/anvr_mem_model.sv */
// behavioural model of the clockless 512k x 16 nonvolatile memory
module anvr_mem_model (
  input  wire        chip_select_n,
  input  wire        write_strobe_n,
  input  wire        output_enable_n,
  input  wire        upper_byte_enable_n,
  input  wire        lower_byte_enable_n,
  input  wire        sleep_request_n,
  input  wire [18:0] word_address_pins,
  input  wire [15:0] data_in,
  output wire [15:0] data_out,
  output wire        asleep
);
  timeunit 1ns;
  timeprecision 1ps;
  // only 256 words are stored: tests keep to distinct low address bytes
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0;
  wire         drive = !chip_select_n && !output_enable_n && !asleep;
  wire [15:0]  rd = mem[word_address_pins[7:0]];
  // sleep starts the moment the request falls, with no enable delay
  assign asleep = !sleep_request_n;
  // a released bus shows the inverse of the last word, so stale data never matches
  assign data_out = drive ? rd : ~last;
  always @(drive or rd) if (drive) last = rd;
  // write-through while strobe and lane are low; asleep, accesses are ignored
  always @(chip_select_n or write_strobe_n or upper_byte_enable_n or lower_byte_enable_n
           or word_address_pins or data_in or asleep) begin
    // pins of one edge change in one step; settle so a half-updated bus never lands
    #0.1;
    if (!chip_select_n && !write_strobe_n && !asleep) begin
      if (!upper_byte_enable_n) mem[word_address_pins[7:0]][15:8] = data_in[15:8];
      if (!lower_byte_enable_n) mem[word_address_pins[7:0]][7:0] = data_in[7:0];
    end
  end
endmodule

/* test/testbench.sv */
// self-checking bench for the nonvolatile memory host controller
`include "anvr_consts.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk        = 1'b0;
  logic                arst_n     = 1'b0;
  logic                low_supply = 1'b1;
  logic                req_valid  = 1'b0;
  logic [2:0]          req_cmd    = 3'h0;
  logic [`ANVR_AW-1:0] req_addr   = 19'h0;
  logic [`ANVR_DW-1:0] req_wdata  = 16'h0;
  logic [1:0]          req_lanes  = 2'h0;
  wire                 ready, rsp_v, safe, cs_n, we_n, oe_n, upr_n, lwr_n, slp_n, oe, asleep;
  wire [`ANVR_DW-1:0]  rdata, dout, mdata, bus;
  wire [`ANVR_AW-1:0]  addr;
  int                  err_total  = 0;
  int                  n_tests    = 0;
  int                  cyc        = 0;

  anvr_host dut_u (
    .clk(clk), .arst_n(arst_n), .low_supply(low_supply), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .req_ready_r(ready), .rsp_valid_r(rsp_v), .rsp_rdata_r(rdata), .power_safe_r(safe),
    .chip_select_n_r(cs_n), .write_strobe_n_r(we_n), .output_enable_n_r(oe_n),
    .upper_byte_enable_n_r(upr_n), .lower_byte_enable_n_r(lwr_n), .sleep_request_n_r(slp_n),
    .word_address_pins_r(addr), .data_pins_out_r(dout), .data_pins_oe_r(oe),
    .data_pins_in(bus));
  assign bus = oe ? dout : mdata;
  anvr_mem_model mem_u (
    .chip_select_n(cs_n), .write_strobe_n(we_n), .output_enable_n(oe_n),
    .upper_byte_enable_n(upr_n), .lower_byte_enable_n(lwr_n), .sleep_request_n(slp_n),
    .word_address_pins(addr), .data_in(bus), .data_out(mdata), .asleep(asleep));

  initial forever #5 clk = ~clk;

  // ----------
  // shared tasks
  // ----------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_rdy(output int n);
    for (n = 0; n < 50000 && ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // request held from just after an edge until the edge that sees ready high
  task automatic issue(input logic [2:0] c, input logic [18:0] a, input logic [15:0] d,
                       input logic [1:0] l);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    wait_rdy(n);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask

  task automatic rd(input logic [2:0] c, input logic [18:0] a, input logic [15:0] exp,
                    input int lat, input string what);
    int n;
    issue(c, a, 16'h0, 2'h3);
    for (n = 0; n < 40 && rsp_v !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(what, rdata, exp);
    chk("latency", n >= lat, 1);
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_write_read;
    issue(`ANVR_CMD_WRITE, 19'h5, 16'ha1b2, 2'h3);
    issue(`ANVR_CMD_WRITE, 19'h7ffff, 16'h1234, 2'h3);
    rd(`ANVR_CMD_READ, 19'h5, 16'ha1b2, `ANVR_AWH_LO_CYC, "rd_a");
    rd(`ANVR_CMD_READ, 19'h7ffff, 16'h1234, `ANVR_AWH_LO_CYC, "rd_top");
    $display("test write_read done");
  endtask

  task automatic t_lanes;
    issue(`ANVR_CMD_WRITE, 19'h5, 16'hc3d4, 2'h2);
    rd(`ANVR_CMD_READ, 19'h5, 16'hc3b2, `ANVR_AWH_LO_CYC, "upper");
    issue(`ANVR_CMD_WRITE, 19'h5, 16'he5f6, 2'h1);
    rd(`ANVR_CMD_READ, 19'h5, 16'hc3f6, `ANVR_AWH_LO_CYC, "lower");
    $display("test lanes done");
  endtask

  task automatic t_page;
    int i;
    for (i = 0; i < 3; i++) issue(`ANVR_CMD_PG_WRITE, 19'h7fff0 + 19'(i), {4{4'(i + 1)}}, 2'h3);
    issue(`ANVR_CMD_PG_END, 19'h0, 16'h0, 2'h0);
    for (i = 0; i < 3; i++)
      rd(`ANVR_CMD_PG_READ, 19'h7fff0 + 19'(i), {4{4'(i + 1)}},
         (i == 0) ? `ANVR_AWH_LO_CYC : `ANVR_PRC_CYC, "page");
    issue(`ANVR_CMD_PG_END, 19'h0, 16'h0, 2'h0);
    $display("test page done");
  endtask

  task automatic t_sleep;
    int n;
    issue(`ANVR_CMD_SLEEP, 19'h0, 16'h0, 2'h0);
    repeat (110) @(posedge clk);
    #1;
    chk("asleep", {slp_n, asleep}, 2'h1);
    chk("idle_pins", {cs_n, we_n, oe_n}, 3'h7);
    issue(`ANVR_CMD_WAKE, 19'h0, 16'h0, 2'h0);
    wait_rdy(n);
    chk("wake_hold", n >= `ANVR_ZZEX_CYC, 1);
    rd(`ANVR_CMD_READ, 19'h5, 16'hc3f6, `ANVR_AWH_LO_CYC, "kept");
    $display("test sleep done");
  endtask

  task automatic t_power_off;
    int n;
    issue(`ANVR_CMD_WRITE, 19'h9, 16'h5a5a, 2'h3);
    issue(`ANVR_CMD_PWR_OFF, 19'h0, 16'h0, 2'h0);
    for (n = 0; n < 40 && safe !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("pd_hold", n >= `ANVR_PD_CYC, 1);
    chk("pd_pins", {safe, cs_n}, 2'h3);
    $display("test power_off done");
  endtask

  // ceiling covers two 45000-cycle holds plus a few hundred cycles of traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    int n;
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    wait_rdy(n);
    chk("pu_hold", {n >= `ANVR_PU_CYC, cs_n}, 2'h3);
    t_write_read;
    t_lanes;
    t_page;
    t_sleep;
    t_power_off;
    test_done;
  end
endmodule
